// ===== rtl/art_pkg.sv
// package for the antenna resonance tuning sequencer
package art_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_COMMAND    = 8'h00;
	localparam logic [7:0] OFS_EXT_TRIM   = 8'h04;
	localparam logic [7:0] OFS_CAL_RESULT = 8'h08;
	localparam logic [7:0] OFS_ADC_RESULT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1C;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CMD_CHECK_BIT     = 0;
	localparam int CMD_CALIBRATE_BIT = 1;
	localparam int EXT_SELECT_BIT    = 4;
	localparam int CAL_ERROR_BIT     = 4;
	localparam int IRQ_CHECK_DONE    = 0;
	localparam int IRQ_CAL_DONE      = 1;
	localparam int IRQ_CAL_ERROR     = 2;
	localparam int IRQ_WIDTH         = 3;

	// ---------------------------------------------------------------
	// values and timing
	// ---------------------------------------------------------------
	localparam logic [7:0] ADC_MID_UPPER = 8'h80;
	localparam logic [7:0] ADC_MID_LOWER = 8'h7F;
	localparam logic [3:0] SWITCH_ALL_ON = 4'hF;
	localparam logic [3:0] SWITCH_ALL_OFF = 4'h0;
	localparam int CLK_MHZ       = 100;
	localparam int SETTLE_US     = 10;
	localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [2:0] {
		ART_IDLE      = 3'b000,
		ART_CHK_CONV  = 3'b001,
		ART_CAL_OPEN  = 3'b010,
		ART_CAL_WAIT  = 3'b011,
		ART_CAL_STEP  = 3'b100
	} art_state_t;

	// adc answer bundle, done flag and code
	typedef struct packed {
		logic       done;
		logic [7:0] code;
	} art_adc_t;

	// calibration result bundle
	typedef struct packed {
		logic       error;
		logic [3:0] code;
	} art_cal_t;

endpackage

// ===== rtl/art_tuning.sv
// resonance check and calibration sequencer with ahb-lite registers
// How it works
// - A check command routes the phase detector to the relative-mode adc, mid-scale meaning tuned.
// - A check code above 8'h80 reports resonance above the 13.56 MHz target.
// - A check code below 8'h7F reports resonance below the target.
// - Calibration decides from the comparator, high meaning resonance above target.
// - Calibration begins by opening every trim switch on both driver sides.
// - A low comparator with all switches open, sampled after the 10 us settle wait, sets the error flag and ends calibration.
// - While the comparator is high the code advances from the lsb, waiting 10 us per step.
// - The code at which the comparator went low is kept applied.
// - All switches closed with the comparator still high sets the error flag.
// - The final four switch bits and the error flag are readable by the host.
// - Each weight drives the switch on both driver sides from one common bit.
// - With external select set, the switches follow the host-written external code.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
module art_tuning (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// phase detector and adc
	input  wire logic        phase_comp,
	output logic             adc_start,
	output logic             adc_mux_phase,
	output logic             adc_relative,
	input  wire logic        adc_done,
	input  wire logic [7:0]  adc_code,
	// trim switch pads, side one and side two
	output logic      [3:0]  capacitor_switch_pads_one,
	output logic      [3:0]  capacitor_switch_pads_two,
	// interrupt
	output logic             irq
);

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic                       wr_pend_q;
	logic [7:0]                 addr_q;
	logic                       ap_valid;
	art_pkg::art_adc_t          adc_in;
	art_pkg::art_cal_t          cal_q;
	art_pkg::art_state_t        state_q;
	logic [7:0]                 adc_q;
	logic                       ext_sel_q;
	logic [3:0]                 external_switch_code_q;
	logic [art_pkg::IRQ_WIDTH-1:0] irq_stat_q;
	logic [art_pkg::IRQ_WIDTH-1:0] irq_en_q;
	logic [art_pkg::IRQ_WIDTH-1:0] irq_set;
	logic [art_pkg::IRQ_WIDTH-1:0] irq_clr;
	logic [9:0]                 settle_q;
	logic                       cmd_check;
	logic                       cmd_cal;
	logic                       busy;
	logic                       above_target;
	logic                       below_target;
	logic [3:0]                 switch_code;

	assign adc_in    = '{done: adc_done, code: adc_code};
	assign ap_valid  = hsel && hready && htrans == art_pkg::HTRANS_NONSEQ;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else begin
			wr_pend_q <= ap_valid && hwrite;
			if (ap_valid) begin
				addr_q <= haddr;
			end
		end
	end

	// commands are pulses, ignored while a command runs
	assign busy      = state_q != art_pkg::ART_IDLE;
	assign cmd_check = wr_pend_q && addr_q == art_pkg::OFS_COMMAND && !busy
		&& hwdata[art_pkg::CMD_CHECK_BIT];
	assign cmd_cal   = wr_pend_q && addr_q == art_pkg::OFS_COMMAND && !busy
		&& !hwdata[art_pkg::CMD_CHECK_BIT] && hwdata[art_pkg::CMD_CALIBRATE_BIT];
	assign irq_clr   = (wr_pend_q && addr_q == art_pkg::OFS_IRQ_CLEAR)
		? hwdata[art_pkg::IRQ_WIDTH-1:0] : '0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_sel_q              <= 1'b0;
			external_switch_code_q <= 4'h0;
			irq_en_q               <= '0;
		end else if (wr_pend_q) begin
			if (addr_q == art_pkg::OFS_EXT_TRIM) begin
				ext_sel_q              <= hwdata[art_pkg::EXT_SELECT_BIT];
				external_switch_code_q <= hwdata[3:0];
			end
			if (addr_q == art_pkg::OFS_IRQ_ENABLE) begin
				irq_en_q <= hwdata[art_pkg::IRQ_WIDTH-1:0];
			end
		end
	end

	// read data registered in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			unique case (haddr)
				art_pkg::OFS_EXT_TRIM:
					hrdata <= {27'h0, ext_sel_q, external_switch_code_q};
				art_pkg::OFS_CAL_RESULT: hrdata <= {27'h0, cal_q};
				art_pkg::OFS_ADC_RESULT: hrdata <= {24'h0, adc_q};
				art_pkg::OFS_IRQ_STATUS: hrdata <= {29'h0, irq_stat_q};
				art_pkg::OFS_IRQ_ENABLE: hrdata <= {29'h0, irq_en_q};
				art_pkg::OFS_STATUS:
					hrdata <= {29'h0, below_target, above_target, busy};
				default: hrdata <= 32'h0000_0000;
			endcase
		end else begin
			hrdata <= 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// check verdict
	// ---------------------------------------------------------------
	// code above upper mid
	assign above_target = adc_q > art_pkg::ADC_MID_UPPER;
	assign below_target = adc_q < art_pkg::ADC_MID_LOWER;

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q  <= art_pkg::ART_IDLE;
			cal_q    <= '0;
			adc_q    <= 8'h00;
			settle_q <= '0;
			irq_set  <= '0;
		end else begin
			irq_set <= '0;
			unique case (state_q)
				art_pkg::ART_IDLE: begin
					if (cmd_check) begin
						state_q <= art_pkg::ART_CHK_CONV;
					end else if (cmd_cal) begin
						cal_q   <= '{error: 1'b0, code: art_pkg::SWITCH_ALL_OFF};
						settle_q <= 10'(art_pkg::SETTLE_CYCLES - 1);
						state_q <= art_pkg::ART_CAL_OPEN;
					end
				end
				art_pkg::ART_CHK_CONV: begin
					if (adc_in.done) begin
						adc_q   <= adc_in.code;
						irq_set[art_pkg::IRQ_CHECK_DONE] <= 1'b1;
						state_q <= art_pkg::ART_IDLE;
					end
				end
				art_pkg::ART_CAL_OPEN, art_pkg::ART_CAL_WAIT: begin
					// wait for tank to settle after a switch change
					if (settle_q != '0) begin
						settle_q <= settle_q - 10'd1;
					end else begin
						state_q <= art_pkg::ART_CAL_STEP;
					end
				end
				art_pkg::ART_CAL_STEP: begin
					if (!phase_comp) begin
						if (state_q == art_pkg::ART_CAL_STEP && cal_q.code == art_pkg::SWITCH_ALL_OFF) begin
							cal_q.error <= 1'b1;
							irq_set[art_pkg::IRQ_CAL_ERROR] <= 1'b1;
						end
						irq_set[art_pkg::IRQ_CAL_DONE] <= 1'b1;
						state_q <= art_pkg::ART_IDLE;
					end else if (cal_q.code == art_pkg::SWITCH_ALL_ON) begin
						cal_q.error <= 1'b1;
						irq_set[art_pkg::IRQ_CAL_ERROR] <= 1'b1;
						irq_set[art_pkg::IRQ_CAL_DONE]  <= 1'b1;
						state_q <= art_pkg::ART_IDLE;
					end else begin
						// step from lsb, then 10 us
						cal_q.code <= cal_q.code + 4'h1;
						settle_q   <= 10'(art_pkg::SETTLE_CYCLES - 1);
						state_q    <= art_pkg::ART_CAL_WAIT;
					end
				end
				default: state_q <= art_pkg::ART_IDLE;
			endcase
		end
	end

	assign adc_mux_phase = state_q == art_pkg::ART_CHK_CONV;
	assign adc_relative  = state_q == art_pkg::ART_CHK_CONV;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adc_start <= 1'b0;
		end else begin
			adc_start <= cmd_check;
		end
	end

	// ---------------------------------------------------------------
	// trim switch drive
	// ---------------------------------------------------------------
	// external code wins when selected
	assign switch_code = ext_sel_q ? external_switch_code_q : cal_q.code;

	// one bit per weight, both sides
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			capacitor_switch_pads_one <= 4'h0;
			capacitor_switch_pads_two <= 4'h0;
		end else begin
			capacitor_switch_pads_one <= switch_code;
			capacitor_switch_pads_two <= switch_code;
		end
	end

	// ---------------------------------------------------------------
	// interrupts
	// ---------------------------------------------------------------
	// set wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

endmodule

// ===== verif/art_tank_model.sv
// tank, comparator and adc stand-in
module art_tank_model (
	// control from bench
	input  wire logic       hclk,
	input  wire logic [4:0] res_code,
	input  wire logic [7:0] phase_code,
	// device side
	input  wire logic [3:0] pads,
	input  wire logic       adc_start,
	output logic            phase_comp,
	output logic            adc_done,
	output logic [7:0]      adc_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] busy_q = 3'h0;
	// ---------------------------------
	// tank and converter
	// ---------------------------------
	// high above target
	assign phase_comp = {1'b0, pads} < res_code;
	// code is junk outside done, so a late sample shows
	assign adc_code = adc_done ? phase_code : ~phase_code;
	assign adc_done = busy_q == 3'h1;
	always_ff @(posedge hclk) begin
		if (adc_start)
			busy_q <= 3'h4;
		else if (busy_q != 3'h0)
			busy_q <= busy_q - 3'h1;
	end
endmodule

// ===== verif/art_tuning_assertions.sv
// port checker for the tuning sequencer
module art_tuning_assertions (
	// bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// analog side
	input wire logic        phase_comp,
	input wire logic        adc_start,
	input wire logic        adc_mux_phase,
	input wire logic        adc_relative,
	input wire logic        adc_done,
	input wire logic [7:0]  adc_code,
	input wire logic [3:0]  capacitor_switch_pads_one,
	input wire logic [3:0]  capacitor_switch_pads_two,
	input wire logic        irq
);
	logic       wr_q;
	logic [7:0] wa_q;
	logic       ext_q;
	logic [3:0] ext_code_q;
	logic [9:0] held_q;
	logic [3:0] pads;
	assign pads = capacitor_switch_pads_one;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ---------------------------------
	// write tracking, settle count
	// ---------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			ext_q <= 1'b0;
			ext_code_q <= 4'h0;
		end else begin
			wr_q <= hsel && hready && htrans == art_pkg::HTRANS_NONSEQ && hwrite;
			wa_q <= haddr;
			if (wr_q && wa_q == art_pkg::OFS_EXT_TRIM) begin
				ext_q <= hwdata[art_pkg::EXT_SELECT_BIT];
				ext_code_q <= hwdata[3:0];
			end
		end
	end
	// saturating, so a long idle span counts as settled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			held_q <= 10'h3FF;
		else if ($changed(pads))
			held_q <= 10'h000;
		else if (held_q != 10'h3FF)
			held_q <= held_q + 10'h001;
	end
	sequence s_launch;
		adc_start ##1 (adc_mux_phase && adc_relative && !adc_start);
	endsequence
	sequence s_step;
		!ext_q && !$past(ext_q, 2) && $changed(pads) && pads != 4'h0;
	endsequence
	property p_launch;
		adc_start |-> s_launch;
	endproperty
	property p_hold;
		adc_mux_phase && !adc_done |=> adc_mux_phase && adc_relative;
	endproperty
	property p_release;
		adc_mux_phase && adc_done |=> !adc_mux_phase && !adc_relative;
	endproperty
	property p_open;
		wr_q && wa_q == art_pkg::OFS_COMMAND && hwdata[1] && !hwdata[0] && !ext_q
			|-> ##[1:3] pads == art_pkg::SWITCH_ALL_OFF;
	endproperty
	property p_step;
		s_step |-> pads == $past(pads) + 4'h1;
	endproperty
	property p_settle;
		s_step |-> held_q >= 10'd999;
	endproperty
	property p_pair;
		capacitor_switch_pads_one == capacitor_switch_pads_two;
	endproperty
	property p_ext;
		ext_q && $past(ext_q) |-> pads == $past(ext_code_q);
	endproperty
	a_launch: assert property (p_launch) else $error("check start not routed");
	a_hold: assert property (p_hold) else $error("adc route dropped early");
	a_release: assert property (p_release) else $error("adc route kept after done");
	a_open: assert property (p_open) else $error("switches not opened");
	a_step: assert property (p_step) else $error("switch code not stepped by one");
	a_settle: assert property (p_settle) else $error("step before settle time");
	a_pair: assert property (p_pair) else $error("driver sides differ");
	a_ext: assert property (p_ext) else $error("switches not on external code");
endmodule
bind art_tuning art_tuning_assertions i_chk (.*);

// ===== verif/testbench.sv
// self-checking bench for the tuning sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        phase_comp;
	logic        adc_start;
	logic        adc_mux_phase;
	logic        adc_relative;
	logic        adc_done;
	logic        irq;
	logic [7:0]  adc_code;
	logic [7:0]  phase_code = 8'h80;
	logic [4:0]  res_code = 5'h00;
	logic [3:0]  capacitor_switch_pads_one;
	logic [3:0]  capacitor_switch_pads_two;
	logic [31:0] rd;
	int          err_total = 0;
	int          n_compared = 0;
	logic [7:0]  codes[4] = '{8'h81, 8'h7E, 8'h80, 8'h7F};
	logic [1:0]  flags[4] = '{2'h1, 2'h2, 2'h0, 2'h0};
	logic [4:0]  res[3] = '{5'h00, 5'h10, 5'h05};
	logic [31:0] cal[3] = '{32'h10, 32'h1F, 32'h05};
	logic [31:0] sts[3] = '{32'h6, 32'h6, 32'h2};
	always #5 hclk = ~hclk;
	art_tuning i_dut (.*, .hready(hreadyout));
	art_tank_model i_tank (
		.hclk       (hclk),
		.res_code   (res_code),
		.phase_code (phase_code),
		.pads       (capacitor_switch_pads_one),
		.adc_start  (adc_start),
		.phase_comp (phase_comp),
		.adc_done   (adc_done),
		.adc_code   (adc_code)
	);
	// ---------------------------------
	// bus and compare tasks
	// ---------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// entered just after an edge; reads see pre-edge values
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= art_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 20000) begin
			@(posedge hclk);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
	endtask
	task automatic conclude();
		$display("mismatches %0d, compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, art_pkg::OFS_CAL_RESULT, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, art_pkg::OFS_IRQ_ENABLE, 32'h7);
		foreach (codes[i]) begin
			phase_code <= codes[i];
			bus(1'b1, art_pkg::OFS_COMMAND, 32'h1);
			wait_irq();
			bus(1'b0, art_pkg::OFS_ADC_RESULT, 32'h0);
			chk(rd, {24'h0, codes[i]});
			bus(1'b0, art_pkg::OFS_STATUS, 32'h0);
			chk(rd, {29'h0, flags[i], 1'b0});
			bus(1'b1, art_pkg::OFS_IRQ_CLEAR, 32'h7);
		end
		foreach (res[i]) begin
			res_code <= res[i];
			bus(1'b1, art_pkg::OFS_COMMAND, 32'h2);
			// check while busy must be dropped, so no check-done bit below
			bus(1'b1, art_pkg::OFS_COMMAND, 32'h1);
			wait_irq();
			bus(1'b0, art_pkg::OFS_CAL_RESULT, 32'h0);
			chk(rd, cal[i]);
			bus(1'b0, art_pkg::OFS_IRQ_STATUS, 32'h0);
			chk(rd, sts[i]);
			chk({28'h0, capacitor_switch_pads_two}, {28'h0, cal[i][3:0]});
			bus(1'b1, art_pkg::OFS_IRQ_CLEAR, 32'h7);
		end
		// masked event stays off the pin
		bus(1'b1, art_pkg::OFS_IRQ_ENABLE, 32'h0);
		bus(1'b1, art_pkg::OFS_COMMAND, 32'h1);
		rd = 32'h0;
		for (int n = 0; n < 50 && rd[0] !== 1'b1; n++)
			bus(1'b0, art_pkg::OFS_IRQ_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, art_pkg::OFS_IRQ_ENABLE, 32'h1);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, art_pkg::OFS_IRQ_CLEAR, 32'h1);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, art_pkg::OFS_EXT_TRIM, 32'h1A);
		repeat (2) @(posedge hclk);
		chk({28'h0, capacitor_switch_pads_one}, 32'hA);
		bus(1'b1, art_pkg::OFS_EXT_TRIM, 32'h0A);
		repeat (2) @(posedge hclk);
		chk({28'h0, capacitor_switch_pads_one}, 32'h5);
		bus(1'b0, art_pkg::OFS_EXT_TRIM, 32'h0);
		chk(rd, 32'hA);
		bus(1'b0, 8'hFC, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		// reset while the sequencer is idle drops the held result
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({28'h0, capacitor_switch_pads_one}, 32'h0);
		bus(1'b0, art_pkg::OFS_CAL_RESULT, 32'h0);
		chk(rd, 32'h0);
		conclude();
	end
endmodule
